/* File: deep_standby_power_control.sv */
// Low-power mode sequencer: sleep, all-module clock stop, standby and
// deep standby, with domain power gating and module stop clock gates.
// Assumes software drives control ports on clk_i; wake and emergency
// sources are asynchronous pins resynchronised here.
`timescale 1ns/1ps

module deep_standby_power_control
#(
    parameter int NUM_TIMERS = 2
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sby_wr_i,
    input  wire logic [15:0] sby_wdata_i,
    input  wire logic        stop_wr_i,
    input  wire logic [1:0]  stop_sel_i,
    input  wire logic [31:0] stop_wdata_i,
    input  wire logic        ret_clk_wr_i,
    input  wire logic [1:0]  ret_clk_wdata_i,
    input  wire logic        lvd_enable_i,
    input  wire logic        wait_exec_i,
    input  wire logic        wake_irq_i,
    input  wire logic        eod_irq_i,
    input  wire logic        eod_irq_en_i,
    input  wire logic        eod_ack_i,
    output logic [15:0]      standby_control_reg_o,
    output logic [31:0]      peripheral_stop_ctrl_a_o,
    output logic [31:0]      peripheral_stop_ctrl_b_o,
    output logic [31:0]      peripheral_stop_ctrl_c_o,
    output logic [31:0]      peripheral_stop_ctrl_d_o,
    output logic [1:0]       sleep_return_clock_select_o,
    output logic [2:0]       power_mode_o,
    output logic             core_clk_en_o,
    output logic             periph_clk_en_o,
    output logic [NUM_TIMERS-1:0] timer_clk_en_o,
    output logic             osc_pll_en_o,
    output logic             core_pwr_en_o,
    output logic             flash_retain_o,
    output logic             port_hold_o,
    output logic             output_port_hold_enable_o,
    output logic             por_enable_o,
    output logic             lvd_run_o,
    output logic             wake_reset_o,
    output logic             wake_irq_o,
    output logic             eod_irq_o
);

    // =====================================================
    // Pin synchronisers, three stages, change on agreement
    logic [2:0] wake_sync_r;
    logic [2:0] eod_sync_r;
    logic       wake_lvl_r;
    logic       eod_lvl_r;
    logic       wake_lvl_nxt;
    logic       eod_lvl_nxt;

    always_comb
    begin
        wake_lvl_nxt = wake_lvl_r;
        eod_lvl_nxt  = eod_lvl_r;
        if (wake_sync_r[1] == wake_sync_r[2])
        begin
            wake_lvl_nxt = wake_sync_r[2];
        end
        if (eod_sync_r[1] == eod_sync_r[2])
        begin
            eod_lvl_nxt = eod_sync_r[2];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wake_sync_r <= 3'h0;
            eod_sync_r  <= 3'h0;
            wake_lvl_r  <= 1'b0;
            eod_lvl_r   <= 1'b0;
        end
        else
        begin
            wake_sync_r <= {wake_sync_r[1:0], wake_irq_i};
            eod_sync_r  <= {eod_sync_r[1:0], eod_irq_i};
            wake_lvl_r  <= wake_lvl_nxt;
            eod_lvl_r   <= eod_lvl_nxt;
        end
    end

    // =====================================================
    // Control registers written by software
    logic [15:0] sby_r;
    logic [15:0] sby_nxt;
    logic [31:0] stop_r [4];
    logic [31:0] stop_nxt [4];
    logic [1:0]  ret_clk_r;
    logic [1:0]  ret_clk_nxt;

    always_comb
    begin
        sby_nxt     = sby_r;
        stop_nxt    = stop_r;
        ret_clk_nxt = ret_clk_r;
        if (sby_wr_i)
        begin
            sby_nxt = sby_wdata_i;
        end
        if (stop_wr_i)
        begin
            stop_nxt[stop_sel_i] = stop_wdata_i;
        end
        if (ret_clk_wr_i)
        begin
            ret_clk_nxt = ret_clk_wdata_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sby_r     <= power_ctrl_pkg::SBY_RESET;
            stop_r[0] <= power_ctrl_pkg::STOP_A_RESET;
            stop_r[1] <= power_ctrl_pkg::STOP_BCD_RESET;
            stop_r[2] <= power_ctrl_pkg::STOP_BCD_RESET;
            stop_r[3] <= power_ctrl_pkg::STOP_BCD_RESET;
            ret_clk_r <= power_ctrl_pkg::RET_CLK_RESET;
        end
        else
        begin
            sby_r     <= sby_nxt;
            stop_r    <= stop_nxt;
            ret_clk_r <= ret_clk_nxt;
        end
    end

    // =====================================================
    // Mode sequencer
    power_ctrl_pkg::power_mode_t mode_r;
    power_ctrl_pkg::power_mode_t mode_nxt;
    logic [7:0] wcnt_r;
    logic [7:0] wcnt_nxt;
    logic       wirq_r;
    logic       wirq_nxt;
    logic       eod_set;
    logic       eod_pend;
    logic       eod_irq_r;
    logic       eod_irq_nxt;

    // Emergency source latched in any mode while eod_irq_en_i is high
    assign eod_set = eod_lvl_r && eod_irq_en_i;

    pending_latch u_eod_pend
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .set_i   (eod_set),
        .clr_i   (eod_ack_i),
        .pend_o  (eod_pend)
    );

    always_comb
    begin
        mode_nxt    = mode_r;
        wcnt_nxt    = wcnt_r;
        wirq_nxt    = 1'b0;
        eod_irq_nxt = 1'b0;
        case (mode_r)
            power_ctrl_pkg::MODE_RUN:
            begin
                eod_irq_nxt = eod_pend;
                if (wait_exec_i)
                begin
                    if (sby_r[power_ctrl_pkg::STBY_BIT])
                    begin
                        mode_nxt = sby_r[power_ctrl_pkg::DEEP_BIT] ?
                            power_ctrl_pkg::MODE_DEEPSTBY :
                            power_ctrl_pkg::MODE_SWSTBY;
                    end
                    else if (sby_r[power_ctrl_pkg::ALLSTOP_BIT])
                    begin
                        mode_nxt = power_ctrl_pkg::MODE_ALLSTOP;
                    end
                    else
                    begin
                        mode_nxt = power_ctrl_pkg::MODE_SLEEP;
                    end
                end
            end
            power_ctrl_pkg::MODE_SLEEP,
            power_ctrl_pkg::MODE_SWSTBY:
            begin
                if (wake_lvl_r)
                begin
                    mode_nxt = power_ctrl_pkg::MODE_RUN;
                    wirq_nxt = 1'b1;
                end
            end
            power_ctrl_pkg::MODE_ALLSTOP:
            begin
                if (wake_lvl_r)
                begin
                    mode_nxt = power_ctrl_pkg::MODE_RUN;
                    wirq_nxt = 1'b1;
                end
            end
            power_ctrl_pkg::MODE_DEEPSTBY:
            begin
                if (wake_lvl_r)
                begin
                    mode_nxt = power_ctrl_pkg::MODE_WAKE;
                    wcnt_nxt = 8'(power_ctrl_pkg::WAKE_RESET_CYC);
                end
            end
            power_ctrl_pkg::MODE_WAKE:
            begin
                wcnt_nxt = wcnt_r - 8'h01;
                if (wcnt_r == 8'h01)
                begin
                    mode_nxt = power_ctrl_pkg::MODE_RUN;
                end
            end
            default:
            begin
                mode_nxt = power_ctrl_pkg::MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mode_r    <= power_ctrl_pkg::MODE_RUN;
            wcnt_r    <= 8'h00;
            wirq_r    <= 1'b0;
            eod_irq_r <= 1'b0;
        end
        else
        begin
            mode_r    <= mode_nxt;
            wcnt_r    <= wcnt_nxt;
            wirq_r    <= wirq_nxt;
            eod_irq_r <= eod_irq_nxt;
        end
    end

    // =====================================================
    // Domain enables derived from mode
    logic in_run;
    logic in_deep;
    logic clk_stopped;

    assign in_run      = (mode_r == power_ctrl_pkg::MODE_RUN);
    assign in_deep     = (mode_r == power_ctrl_pkg::MODE_DEEPSTBY);
    assign clk_stopped = (mode_r == power_ctrl_pkg::MODE_SWSTBY) || in_deep;

    assign core_clk_en_o   = in_run;
    assign periph_clk_en_o = in_run || (mode_r == power_ctrl_pkg::MODE_SLEEP);
    assign osc_pll_en_o    = !clk_stopped;
    assign core_pwr_en_o   = !in_deep && (mode_r != power_ctrl_pkg::MODE_WAKE);
    assign flash_retain_o  = in_deep;
    assign port_hold_o     = in_deep;
    assign output_port_hold_enable_o = sby_r[power_ctrl_pkg::PORT_HOLD_BIT];
    assign por_enable_o    = 1'b1;
    assign lvd_run_o       = lvd_enable_i;
    assign wake_reset_o    = (mode_r == power_ctrl_pkg::MODE_WAKE);
    assign wake_irq_o      = wirq_r;
    assign eod_irq_o       = eod_irq_r;

    localparam int TIMER_BIT[2] = '{power_ctrl_pkg::TIMER0_STOP_BIT,
                                    power_ctrl_pkg::TIMER1_STOP_BIT};
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++)
        begin : g_timer
            assign timer_clk_en_o[g] = periph_clk_en_o &&
                !stop_r[0][TIMER_BIT[g % 2]];
        end
    endgenerate

    assign standby_control_reg_o       = sby_r;
    assign peripheral_stop_ctrl_a_o    = stop_r[0];
    assign peripheral_stop_ctrl_b_o    = stop_r[1];
    assign peripheral_stop_ctrl_c_o    = stop_r[2];
    assign peripheral_stop_ctrl_d_o    = stop_r[3];
    assign sleep_return_clock_select_o = ret_clk_r;
    assign power_mode_o                = mode_r;

endmodule

/* File: power_ctrl_pkg.sv */
// Constants used by the deep standby power controller; the latch uses none.
// Assumes a single 40 MHz clock domain and software-driven control ports.
package power_ctrl_pkg;

    // =====================================================
    // Power modes
    typedef enum logic [2:0]
    {
        MODE_RUN      = 3'b000,
        MODE_SLEEP    = 3'b001,
        MODE_ALLSTOP  = 3'b010,
        MODE_SWSTBY   = 3'b011,
        MODE_DEEPSTBY = 3'b100,
        MODE_WAKE     = 3'b101
    } power_mode_t;

    // =====================================================
    // Control field positions and reset values
    localparam int          PORT_HOLD_BIT    = 15;
    localparam int          DEEP_BIT         = 14;
    localparam int          STBY_BIT         = 13;
    localparam int          ALLSTOP_BIT      = 12;
    localparam int          TIMER0_STOP_BIT  = 5;
    localparam int          TIMER1_STOP_BIT  = 4;
    localparam logic [15:0] SBY_RESET        = 16'h0000;
    localparam logic [31:0] STOP_A_RESET     = 32'hffff_ffff;
    localparam logic [31:0] STOP_BCD_RESET   = 32'hffff_ffff;
    localparam logic [1:0]  RET_CLK_RESET    = 2'h0;

    // =====================================================
    // Timing: reset pulse after deep standby wake
    localparam int          WAKE_RESET_NS    = 100;
    localparam int          CLK_PERIOD_NS    = 25;
    localparam int          WAKE_RESET_CYC   =
        (WAKE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: pending_latch.sv */
// Sticky pending latch for the emergency output disable interrupt.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps

module pending_latch
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      pend_o
);

    logic pend_r;
    logic pend_nxt;

    // =====================================================
    // Set wins over clear in the same cycle
    always_comb
    begin
        pend_nxt = pend_r;
        if (clr_i)
        begin
            pend_nxt = 1'b0;
        end
        if (set_i)
        begin
            pend_nxt = 1'b1;
        end
    end

    // Register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pend_r <= 1'b0;
        end
        else
        begin
            pend_r <= pend_nxt;
        end
    end

    assign pend_o = pend_r;

endmodule

/* File: power_properties.sv */
// Port checker for the deep standby power controller.
// Assumes it is bound onto the controller; one clock, sync reset.
`timescale 1ns/1ps

module power_properties
#(
    parameter int NUM_TIMERS = 2
)
(
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    input wire logic               ret_clk_wr_i,
    input wire logic [1:0]         ret_clk_wdata_i,
    input wire logic               lvd_enable_i,
    input wire logic               wake_irq_i,
    input wire logic [15:0]        standby_control_reg_o,
    input wire logic [31:0]        peripheral_stop_ctrl_a_o,
    input wire logic [1:0]         sleep_return_clock_select_o,
    input wire logic [2:0]         power_mode_o,
    input wire logic               periph_clk_en_o,
    input wire logic [NUM_TIMERS-1:0] timer_clk_en_o,
    input wire logic               osc_pll_en_o,
    input wire logic               core_pwr_en_o,
    input wire logic               flash_retain_o,
    input wire logic               port_hold_o,
    input wire logic               output_port_hold_enable_o,
    input wire logic               por_enable_o,
    input wire logic               lvd_run_o,
    input wire logic               wake_reset_o,
    input wire logic               eod_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // =====================================================
    // Mode step sequences
    sequence deep_left_s;
        power_mode_o == 3'h4 ##1 power_mode_o != 3'h4;
    endsequence
    sequence allstop_quiet_s;
        (power_mode_o == 3'h2 && !wake_irq_i)[*6];
    endsequence

    // =====================================================
    // Mode and domain checks
    chk_deep_exit_reset:
    assert property (deep_left_s |-> power_mode_o == 3'h5 && wake_reset_o)
        else $error("deep exit skipped reset");
    chk_wake_reset_len:
    assert property ($rose(wake_reset_o) |-> wake_reset_o[*4] ##1 !wake_reset_o)
        else $error("wake reset length wrong");
    chk_deep_domains:
    assert property (power_mode_o == 3'h4 |-> !core_pwr_en_o && !osc_pll_en_o
        && flash_retain_o && port_hold_o)
        else $error("deep standby domains wrong");
    chk_por_always_on:
    assert property (por_enable_o)
        else $error("power-on reset off");
    chk_lvd_follows:
    assert property (lvd_run_o == lvd_enable_i)
        else $error("voltage detect mismatch");
    chk_eod_no_wake:
    assert property (allstop_quiet_s |=> power_mode_o == 3'h2)
        else $error("clock stop left without wake");
    chk_eod_after_run:
    assert property (eod_irq_o |-> $past(power_mode_o) == 3'h0)
        else $error("emergency irq outside run");
    chk_timer_gates:
    assert property (timer_clk_en_o[0] == (periph_clk_en_o
        && !peripheral_stop_ctrl_a_o[5]) && timer_clk_en_o[1]
        == (periph_clk_en_o && !peripheral_stop_ctrl_a_o[4]))
        else $error("timer clock gate wrong");
    chk_ret_clk_write:
    assert property (ret_clk_wr_i |=>
        sleep_return_clock_select_o == $past(ret_clk_wdata_i))
        else $error("return clock not written");
    chk_hold_en_mirror:
    assert property (output_port_hold_enable_o == standby_control_reg_o[15])
        else $error("port hold enable mismatch");
endmodule

/* File: deep_standby_power_control_tb.sv */
// Self-checking bench for the deep standby power controller.
// Assumes a 40 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps

module deep_standby_power_control_tb;
    logic        clk_i = 0, rst_n_i = 0, sby_wr_i = 0, stop_wr_i = 0;
    logic        ret_clk_wr_i = 0, lvd_enable_i = 0, wait_exec_i = 0;
    logic        wake_irq_i = 0, eod_irq_i = 0, eod_irq_en_i = 0;
    logic        eod_ack_i = 0;
    logic [15:0] sby_wdata_i = 16'h0000;
    logic [1:0]  stop_sel_i = 2'h0, ret_clk_wdata_i = 2'h0;
    logic [31:0] stop_wdata_i = 32'h0000_0000;
    logic [15:0] standby_control_reg_o;
    logic [31:0] peripheral_stop_ctrl_a_o, peripheral_stop_ctrl_b_o;
    logic [31:0] peripheral_stop_ctrl_c_o, peripheral_stop_ctrl_d_o;
    logic [1:0]  sleep_return_clock_select_o, timer_clk_en_o;
    logic [2:0]  power_mode_o;
    logic        core_clk_en_o, periph_clk_en_o, osc_pll_en_o;
    logic        core_pwr_en_o, flash_retain_o, port_hold_o, eod_irq_o;
    logic        output_port_hold_enable_o, por_enable_o, lvd_run_o;
    logic        wake_reset_o, wake_irq_o;
    int          err_total = 0, samples_checked = 0;

    // Clock at 25 ns period
    always #12.5 clk_i = ~clk_i;

    deep_standby_power_control #(.NUM_TIMERS(2)) dut_u (.*);

    // =====================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic enter(input logic [15:0] d);
        sby_wdata_i = d;
        sby_wr_i = 1;
        tick(1);
        sby_wr_i = 0;
        wait_exec_i = 1;
        tick(1);
        wait_exec_i = 0;
    endtask
    task automatic until_mode(input logic [2:0] m);
        for (int i = 0; i < 40 && power_mode_o !== m; i++) tick(1);
        chk(power_mode_o, m);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // =====================================================
    // Scenarios
    task automatic t_reset();
        chk(standby_control_reg_o, 32'h0000_0000);
        chk(peripheral_stop_ctrl_a_o, 32'hffff_ffff);
        chk(peripheral_stop_ctrl_d_o, 32'hffff_ffff);
        chk(sleep_return_clock_select_o, 32'h0000_0000);
        chk(timer_clk_en_o, 32'h0000_0000);
        $display("reset values done");
    endtask
    task automatic t_regs();
        sby_wdata_i = 16'h8000;
        sby_wr_i = 1;
        ret_clk_wdata_i = 2'h3;
        ret_clk_wr_i = 1;
        stop_wdata_i = 32'hffff_ffdf;
        stop_wr_i = 1;
        lvd_enable_i = 1;
        tick(1);
        {sby_wr_i, ret_clk_wr_i, stop_wr_i} = 3'h0;
        chk(output_port_hold_enable_o, 32'h0000_0001);
        chk(sleep_return_clock_select_o, 32'h0000_0003);
        chk(timer_clk_en_o, 32'h0000_0001);
        chk(lvd_run_o, 32'h0000_0001);
        stop_wdata_i = 32'hffff_ffef;
        stop_wr_i = 1;
        tick(1);
        stop_sel_i = 2'h1;
        stop_wdata_i = 32'h0000_0000;
        tick(1);
        stop_wr_i = 0;
        chk(peripheral_stop_ctrl_b_o, 32'h0000_0000);
        chk(peripheral_stop_ctrl_a_o, 32'hffff_ffef);
        chk(timer_clk_en_o, 32'h0000_0002);
        $display("register writes done");
    endtask
    task automatic t_deep();
        enter(16'h6000);
        until_mode(3'h4);
        chk({core_pwr_en_o, osc_pll_en_o}, 32'h0000_0000);
        chk({flash_retain_o, port_hold_o}, 32'h0000_0003);
        chk(por_enable_o, 32'h0000_0001);
        chk({core_clk_en_o, periph_clk_en_o}, 32'h0000_0000);
        wake_irq_i = 1;
        until_mode(3'h5);
        chk(wake_reset_o, 32'h0000_0001);
        wake_irq_i = 0;
        until_mode(3'h0);
        $display("deep standby done");
    endtask
    task automatic t_soft();
        logic seen;
        seen = 0;
        enter(16'h2000);
        until_mode(3'h3);
        wake_irq_i = 1;
        repeat (20)
        begin
            tick(1);
            seen |= wake_irq_o;
        end
        wake_irq_i = 0;
        chk(seen, 32'h0000_0001);
        chk(power_mode_o, 32'h0000_0000);
        // Let the wake level settle low before the next wait
        tick(6);
        enter(16'h0000);
        until_mode(3'h1);
        chk({core_clk_en_o, periph_clk_en_o}, 32'h0000_0001);
        wake_irq_i = 1;
        until_mode(3'h0);
        wake_irq_i = 0;
        tick(6);
        $display("software standby done");
    endtask
    task automatic t_eod();
        eod_irq_en_i = 1;
        enter(16'h1000);
        until_mode(3'h2);
        eod_irq_i = 1;
        tick(12);
        eod_irq_i = 0;
        chk(power_mode_o, 32'h0000_0002);
        chk(eod_irq_o, 32'h0000_0000);
        wake_irq_i = 1;
        until_mode(3'h0);
        wake_irq_i = 0;
        tick(3);
        chk(eod_irq_o, 32'h0000_0001);
        eod_ack_i = 1;
        tick(1);
        eod_ack_i = 0;
        tick(2);
        chk(eod_irq_o, 32'h0000_0000);
        $display("emergency pending done");
    endtask

    // Main sequence
    initial
    begin
        tick(5);
        rst_n_i = 1;
        tick(1);
        t_reset();
        t_regs();
        t_deep();
        t_soft();
        t_eod();
        finish_test();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        #50000;
        err_total++;
        finish_test();
    end
endmodule

bind deep_standby_power_control power_properties
    #(.NUM_TIMERS(NUM_TIMERS)) chk_u (.*);
